// *** hdl/dbs_top.sv ***
// Data buffer steering between processor, memory, peripheral and slot data buses.
// Assumes the system and bus controllers drive strobes as ordinary synchronous or pin inputs.
`timescale 1ns/1ps

module dbs_top
  import dbs_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  input  wire dbs_mode_type          i_mode,
  input  wire logic                  i_mem_write,
  input  wire logic                  i_cache_present,
  input  wire logic                  i_posted_wr_strobe,
  input  wire logic                  i_dram_on_cpu_bus,
  input  wire logic                  i_bus_hold_ack,
  input  wire logic                  i_three_state_n,
  input  wire logic                  i_memory_latch_strobe_n,
  input  wire logic [DBS_LANES-1:0]  i_latched_byte_lane_enables_n,
  input  wire logic                  i_low_byte_latch_strobe_n,
  input  wire logic                  i_high_byte_latch_strobe_n,
  input  wire logic                  i_word_half_select_bit,
  input  wire logic                  i_swap_direction_select,
  input  wire logic                  i_swap_qualify_enable_n,
  input  wire logic                  i_peripheral_read_direction_n,
  input  wire logic [1:0]            i_write_lane_select,
  input  wire logic [DBS_CPU_W-1:0]  i_cpu_data,
  input  wire logic [DBS_MEM_W-1:0]  i_memory_side_data_bus,
  input  wire logic [DBS_LANES-1:0]  i_mem_parity,
  input  wire logic [DBS_PER_W-1:0]  i_peripheral_side_data_bus,
  input  wire logic [DBS_SLOT_W-1:0] i_slot_side_data_bus,
  output logic [DBS_CPU_W-1:0]       o_cpu_data,
  output logic                       o_cpu_data_oe_n,
  output logic [DBS_MEM_W-1:0]       o_memory_side_data_bus,
  output logic [DBS_LANES-1:0]       o_mem_parity,
  output logic                       o_mem_oe_n,
  output logic [DBS_PER_W-1:0]       o_peripheral_side_data_bus,
  output logic                       o_peripheral_oe_n,
  output logic [DBS_SLOT_W-1:0]      o_slot_side_data_bus,
  output logic                       o_slot_oe_n,
  output logic                       o_parity_fault_output_n,
  output logic                       o_cpu_bus_size_halfword_input_n
);

  // Strobes come from other chips: three-stage synchronisers, act when stages 2 and 3 agree.
  logic [2:0] mlat_sync_reg, lo_sync_reg, hi_sync_reg, pw_sync_reg;
  logic [2:0] mlat_sync_next, lo_sync_next, hi_sync_next, pw_sync_next;
  logic       mlat_fall, lo_fall, hi_fall, pw_rise;
  logic [3:0] lvl_reg, lvl_next;

  logic [31:0] mem_latch_reg, mem_latch_next;
  logic [31:0] asm_latch_reg, asm_latch_next;
  logic [31:0] post_reg, post_next;
  logic        pend_err_reg, pend_err_next;
  logic        fault_reg, fault_next;
  logic [31:0] cpu_out_reg, cpu_out_next;
  logic [31:0] mem_out_reg, mem_out_next;
  logic [3:0]  par_out_reg, par_out_next;
  logic [7:0]  per_out_reg, per_out_next;
  logic [15:0] slot_out_reg, slot_out_next;
  logic        cpu_oe_reg, cpu_oe_next;
  logic        mem_oe_reg, mem_oe_next;
  logic        per_oe_reg, per_oe_next;
  logic        slot_oe_reg, slot_oe_next;
  logic [31:0] wr_src;
  logic [15:0] wr_half;
  logic [7:0]  wr_byte;
  logic        cur_err;
  logic [7:0]  lo_src, hi_src;

  // Level taken only when stages 2 and 3 agree, so a glitch never makes an edge
  function automatic logic sync_level(input logic [2:0] s, input logic prev);
    sync_level = (s[DBS_SYNC_PREV] == s[DBS_SYNC_LAST]) ? s[DBS_SYNC_LAST] : prev;
  endfunction : sync_level

  always_comb
  begin
    mlat_sync_next = {mlat_sync_reg[1:0], i_memory_latch_strobe_n};
    lo_sync_next   = {lo_sync_reg[1:0], i_low_byte_latch_strobe_n};
    hi_sync_next   = {hi_sync_reg[1:0], i_high_byte_latch_strobe_n};
    pw_sync_next   = {pw_sync_reg[1:0], i_posted_wr_strobe};
    lvl_next[0]    = sync_level(mlat_sync_reg, lvl_reg[0]);
    lvl_next[1]    = sync_level(lo_sync_reg, lvl_reg[1]);
    lvl_next[2]    = sync_level(hi_sync_reg, lvl_reg[2]);
    lvl_next[3]    = sync_level(pw_sync_reg, lvl_reg[3]);
    mlat_fall = lvl_reg[0] & ~lvl_next[0];
    lo_fall   = lvl_reg[1] & ~lvl_next[1];
    hi_fall   = lvl_reg[2] & ~lvl_next[2];
    pw_rise   = ~lvl_reg[3] & lvl_next[3];
  end

  always_comb
  begin
    mem_latch_next = mem_latch_reg;
    asm_latch_next = asm_latch_reg;
    post_next      = post_reg;
    pend_err_next  = pend_err_reg;
    fault_next     = fault_reg;
    cur_err        = 1'b0;
    for (int i = 0; i < DBS_LANES; i++)
    begin
      if (!i_latched_byte_lane_enables_n[i] &&
          dbs_odd_par(i_memory_side_data_bus[8*i +: 8]) != i_mem_parity[i])
      begin
        cur_err = 1'b1;
      end
    end
    if (mlat_fall && !i_mem_write)
    begin
      mem_latch_next = i_memory_side_data_bus;
      fault_next     = ~pend_err_reg;
      pend_err_next  = cur_err;
    end
    // Byte-wide peripheral reads fill upper lanes too, so both strobes take the same source
    lo_src = (i_mode == DBS_MODE_MEM) ? i_memory_side_data_bus[7:0]
           : (i_mode == DBS_MODE_PER) ? i_peripheral_side_data_bus
                                      : i_slot_side_data_bus[7:0];
    hi_src = (i_mode == DBS_MODE_MEM) ? i_memory_side_data_bus[15:8]
           : (i_mode == DBS_MODE_PER) ? i_peripheral_side_data_bus
                                      : i_slot_side_data_bus[15:8];
    if (lo_fall)
    begin
      asm_latch_next[23:16] = lo_src;
      if (!i_word_half_select_bit)
      begin
        asm_latch_next[7:0] = lo_src;
      end
    end
    if (hi_fall)
    begin
      asm_latch_next[31:24] = hi_src;
      if (!i_word_half_select_bit)
      begin
        asm_latch_next[15:8] = hi_src;
      end
    end
    if (pw_rise && i_cache_present)
    begin
      post_next = i_cpu_data;
    end
  end

  always_comb
  begin
    wr_src  = i_cache_present ? post_reg : i_cpu_data;
    wr_half = i_write_lane_select[1] ? wr_src[31:16] : wr_src[15:0];
    wr_byte = wr_src[8*i_write_lane_select +: 8];
    cpu_out_next  = asm_latch_reg;
    mem_out_next  = wr_src;
    per_out_next  = wr_byte;
    slot_out_next = wr_half;
    cpu_oe_next   = 1'b1;
    mem_oe_next   = 1'b1;
    per_oe_next   = 1'b1;
    slot_oe_next  = 1'b1;
    if (i_bus_hold_ack || i_mode == DBS_MODE_DMA)
    begin
      // Master owns the bus: peripheral and slot bytes steer onto memory and back.
      mem_out_next  = {16'h0000, i_slot_side_data_bus[15:8],
                       i_peripheral_read_direction_n ? i_slot_side_data_bus[7:0]
                                                     : i_peripheral_side_data_bus};
      per_out_next  = i_memory_side_data_bus[7:0];
      slot_out_next = i_memory_side_data_bus[15:0];
      mem_oe_next   = ~i_mem_write;
      slot_oe_next  = i_mem_write;
    end
    else if (i_mode == DBS_MODE_MEM)
    begin
      cpu_out_next = (i_cache_present || !i_dram_on_cpu_bus) ? mem_latch_reg
                                                             : asm_latch_reg;
      cpu_oe_next  = i_mem_write;
      mem_oe_next  = ~i_mem_write;
    end
    else if (i_mode == DBS_MODE_SLOT || i_mode == DBS_MODE_PER)
    begin
      cpu_oe_next  = 1'b0;
      slot_oe_next = (i_mode != DBS_MODE_SLOT);
    end
    if (!i_swap_qualify_enable_n)
    begin
      slot_out_next = i_swap_direction_select
                    ? {i_slot_side_data_bus[7:0], i_slot_side_data_bus[7:0]}
                    : {i_slot_side_data_bus[15:8], i_slot_side_data_bus[15:8]};
      slot_oe_next  = 1'b0;
    end
    per_oe_next = ~i_peripheral_read_direction_n;
    if (i_mode == DBS_MODE_SLOT2SL || !i_three_state_n)
    begin
      cpu_oe_next  = 1'b1;
      mem_oe_next  = 1'b1;
      per_oe_next  = 1'b1;
      slot_oe_next = 1'b1;
    end
    for (int i = 0; i < DBS_LANES; i++)
    begin
      par_out_next[i] = dbs_odd_par(mem_out_next[8*i +: 8]);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mlat_sync_reg <= DBS_SYNC_RST;
      lo_sync_reg   <= DBS_SYNC_RST;
      hi_sync_reg   <= DBS_SYNC_RST;
      pw_sync_reg   <= 3'h0;
      lvl_reg       <= DBS_LVL_RST;
      mem_latch_reg <= DBS_DATA_RST;
      asm_latch_reg <= DBS_DATA_RST;
      post_reg      <= DBS_DATA_RST;
      pend_err_reg  <= 1'b0;
      fault_reg     <= DBS_FAULT_RST;
      cpu_out_reg   <= DBS_DATA_RST;
      mem_out_reg   <= DBS_DATA_RST;
      par_out_reg   <= DBS_PAR_RST;
      per_out_reg   <= 8'h00;
      slot_out_reg  <= 16'h0000;
      cpu_oe_reg    <= 1'b1;
      mem_oe_reg    <= 1'b1;
      per_oe_reg    <= 1'b1;
      slot_oe_reg   <= 1'b1;
    end
    else
    begin
      mlat_sync_reg <= mlat_sync_next;
      lo_sync_reg   <= lo_sync_next;
      hi_sync_reg   <= hi_sync_next;
      pw_sync_reg   <= pw_sync_next;
      lvl_reg       <= lvl_next;
      mem_latch_reg <= mem_latch_next;
      asm_latch_reg <= asm_latch_next;
      post_reg      <= post_next;
      pend_err_reg  <= pend_err_next;
      fault_reg     <= fault_next;
      cpu_out_reg   <= cpu_out_next;
      mem_out_reg   <= mem_out_next;
      par_out_reg   <= par_out_next;
      per_out_reg   <= per_out_next;
      slot_out_reg  <= slot_out_next;
      cpu_oe_reg    <= cpu_oe_next;
      mem_oe_reg    <= mem_oe_next;
      per_oe_reg    <= per_oe_next;
      slot_oe_reg   <= slot_oe_next;
    end
  end

  assign o_cpu_data                      = cpu_out_reg;
  assign o_cpu_data_oe_n                 = cpu_oe_reg;
  assign o_memory_side_data_bus          = mem_out_reg;
  assign o_mem_parity                    = par_out_reg;
  assign o_mem_oe_n                      = mem_oe_reg;
  assign o_peripheral_side_data_bus      = per_out_reg;
  assign o_peripheral_oe_n               = per_oe_reg;
  assign o_slot_side_data_bus            = slot_out_reg;
  assign o_slot_oe_n                     = slot_oe_reg;
  assign o_parity_fault_output_n         = fault_reg;
  // Held inactive: width conversion happens in the assembly latch instead.
  assign o_cpu_bus_size_halfword_input_n = 1'b1;

  chk_three_state_all: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_three_state_n |=> (cpu_oe_reg && mem_oe_reg && per_oe_reg && slot_oe_reg))
    else $error("outputs not released under three-state test");
  chk_slot_pair_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_mode == DBS_MODE_SLOT2SL) |=> (o_cpu_data_oe_n && o_mem_oe_n && o_slot_oe_n))
    else $error("outputs driven during slot to slot transfer");
  chk_per_dir_follow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_three_state_n && i_mode != DBS_MODE_SLOT2SL)
      |=> (o_peripheral_oe_n == ~$past(i_peripheral_read_direction_n)))
    else $error("peripheral bus enable does not follow direction");
  chk_bus_size_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_cpu_bus_size_halfword_input_n)
    else $error("halfword bus size asserted");
  chk_parity_gen_ok: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_mem_oe_n |-> (dbs_odd_par(o_memory_side_data_bus[7:0]) == o_mem_parity[0]))
    else $error("write parity wrong on lane 0");
  chk_mem_latch_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !(mlat_fall && !i_mem_write) |=> (mem_latch_reg == $past(mem_latch_reg)))
    else $error("memory latch changed without strobe");
  chk_fault_delay: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (mlat_fall && !i_mem_write) |=> (fault_reg == ~$past(pend_err_reg)))
    else $error("parity fault not reported on following read");
  chk_low_lane_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (lo_fall && i_word_half_select_bit) |=> (asm_latch_reg[7:0] == $past(asm_latch_reg[7:0])))
    else $error("low lane loaded with half select high");
  cov_mem_read: cover property (@(posedge i_ref_clk) mlat_fall && !i_mem_write);
  cov_fault_seen: cover property (@(posedge i_ref_clk) !o_parity_fault_output_n);
  cov_swap: cover property (@(posedge i_ref_clk) !i_swap_qualify_enable_n);
  cov_assemble: cover property (@(posedge i_ref_clk) lo_fall ##[1:20] hi_fall);

endmodule : dbs_top

// *** hdl/dbs_pkg.sv ***
// Package for the data buffer steering block: lane widths, reset values, steering modes.
// Assumes a single 250 MHz reference clock and an active-low asynchronous reset.
package dbs_pkg;
  localparam int          DBS_CPU_W     = 32;
  localparam int          DBS_MEM_W     = 32;
  localparam int          DBS_SLOT_W    = 16;
  localparam int          DBS_PER_W     = 8;
  localparam int          DBS_LANES     = 4;
  localparam logic [31:0] DBS_DATA_RST  = 32'h0000_0000;
  localparam logic [3:0]  DBS_PAR_RST   = 4'h0;
  localparam logic [2:0]  DBS_SYNC_RST  = 3'h7;
  localparam logic [3:0]  DBS_LVL_RST   = 4'h7;
  localparam logic        DBS_FAULT_RST = 1'b1;
  localparam int          DBS_SYNC_LAST = 2;
  localparam int          DBS_SYNC_PREV = 1;

  // Steering modes chosen by the bus controller.
  typedef enum logic [5:0] {
    DBS_MODE_IDLE    = 6'h01,
    DBS_MODE_MEM     = 6'h02,
    DBS_MODE_PER     = 6'h04,
    DBS_MODE_SLOT    = 6'h08,
    DBS_MODE_DMA     = 6'h10,
    DBS_MODE_SLOT2SL = 6'h20
  } dbs_mode_type;

  // Odd parity of one byte.
  function automatic logic dbs_odd_par(input logic [7:0] b);
    dbs_odd_par = ~(^b);
  endfunction : dbs_odd_par
endpackage : dbs_pkg

// *** dv/dbs_partner.sv ***
// Bus and system controller strobe model for the steering block.
// Assumes the bench calls its tasks; pins change at the falling edge.
`timescale 1ns/1ps
module dbs_partner
(
  input  wire logic i_ref_clk,
  output logic      o_lo_n,
  output logic      o_hi_n,
  output logic      o_md_n,
  output logic      o_dir,
  output logic      o_swap_n
);
  initial
  begin
    {o_lo_n, o_hi_n, o_md_n, o_swap_n} = 4'hf;
    o_dir = 1'b0;
  end

  // Held low 4 clocks, then idle 6, so the pin synchroniser sees each edge
  task automatic pulse(input logic [1:0] which);
    @(negedge i_ref_clk);
    if (which == 2'h0)
      o_lo_n = 1'b0;
    else if (which == 2'h1)
      o_hi_n = 1'b0;
    else
      o_md_n = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    {o_lo_n, o_hi_n, o_md_n} = 3'h7;
    repeat (6) @(negedge i_ref_clk);
  endtask : pulse

  task automatic swap(input logic dir, input logic en_n);
    @(negedge i_ref_clk);
    o_dir    = dir;
    o_swap_n = en_n;
  endtask : swap
endmodule : dbs_partner

// *** dv/dbs_top_tb.sv ***
// Self-checking bench for the data buffer steering block.
// Assumes the partner model drives the latch strobes and swap controls; the bench drives the posted write strobe.
`timescale 1ns/1ps
module dbs_top_tb
  import dbs_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  dbs_mode_type mode = DBS_MODE_IDLE;
  logic         wr = 1'b0, cache = 1'b0, pws = 1'b0, dcpu = 1'b0;
  logic         hold = 1'b0, tri_n = 1'b1, half = 1'b0, rd_n = 1'b1;
  logic [3:0]   lbe_n = 4'h0, mpar = 4'h0;
  logic [1:0]   lsel = 2'h0;
  logic [31:0]  cpu = 32'h0, md = 32'h0;
  logic [7:0]   xd = 8'h0;
  logic [15:0]  sd = 16'h0;
  wire  [31:0]  cdo, mdo;
  wire  [3:0]   mpo;
  wire  [7:0]   xdo;
  wire  [15:0]  sdo;
  wire          c_oe, m_oe, x_oe, s_oe, fault_n, hw_n;
  wire          lo_n, hi_n, md_n, dir, swap_n;
  int           n_errors = 0;
  int           samples_checked = 0;

  always #2 clk = ~clk;

  dbs_partner u_dbs_partner (.i_ref_clk(clk), .o_lo_n(lo_n), .o_hi_n(hi_n),
    .o_md_n(md_n), .o_dir(dir), .o_swap_n(swap_n));

  dbs_top u_dbs_top (.i_ref_clk(clk), .i_rst_n(rst_n), .i_mode(mode),
    .i_mem_write(wr), .i_cache_present(cache), .i_posted_wr_strobe(pws),
    .i_dram_on_cpu_bus(dcpu), .i_bus_hold_ack(hold), .i_three_state_n(tri_n),
    .i_memory_latch_strobe_n(md_n), .i_latched_byte_lane_enables_n(lbe_n),
    .i_low_byte_latch_strobe_n(lo_n), .i_high_byte_latch_strobe_n(hi_n),
    .i_word_half_select_bit(half), .i_swap_direction_select(dir),
    .i_swap_qualify_enable_n(swap_n), .i_peripheral_read_direction_n(rd_n),
    .i_write_lane_select(lsel), .i_cpu_data(cpu), .i_memory_side_data_bus(md),
    .i_mem_parity(mpar), .i_peripheral_side_data_bus(xd),
    .i_slot_side_data_bus(sd), .o_cpu_data(cdo), .o_cpu_data_oe_n(c_oe),
    .o_memory_side_data_bus(mdo), .o_mem_parity(mpo), .o_mem_oe_n(m_oe),
    .o_peripheral_side_data_bus(xdo), .o_peripheral_oe_n(x_oe),
    .o_slot_side_data_bus(sdo), .o_slot_oe_n(s_oe),
    .o_parity_fault_output_n(fault_n), .o_cpu_bus_size_halfword_input_n(hw_n));

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w

  // Odd parity per byte, worked out here rather than borrowed
  function automatic logic [3:0] par4(input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      par4[i] = ~(^d[8*i+:8]);
  endfunction : par4

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic t_reset;
    cmp("oe in reset", 32'hf, {28'h0, c_oe, m_oe, x_oe, s_oe});
    cmp("fault in reset", 32'h1, {31'h0, fault_n});
  endtask : t_reset

  task automatic t_tri;
    mode = DBS_MODE_PER;
    rd_n = 1'b1;
    tri_n = 1'b0;
    w(3);
    cmp("oe tri", 32'hf, {28'h0, c_oe, m_oe, x_oe, s_oe});
    tri_n = 1'b1;
    w(3);
    cmp("xd oe drive", 32'h0, {31'h0, x_oe});
    rd_n = 1'b0;
    w(3);
    cmp("xd oe read", 32'h1, {31'h0, x_oe});
  endtask : t_tri

  task automatic t_s2s;
    mode = DBS_MODE_SLOT2SL;
    wr = 1'b1;
    rd_n = 1'b1;
    w(3);
    cmp("oe slot2slot", 32'hf, {28'h0, c_oe, m_oe, x_oe, s_oe});
  endtask : t_s2s

  task automatic t_narrow;
    mode = DBS_MODE_PER;
    rd_n = 1'b1;
    cpu = 32'h4433_2211;
    for (int i = 0; i < 4; i++)
    begin
      lsel = 2'(i);
      w(3);
      cmp("xd lane", {24'h0, cpu[8*i+:8]}, {24'h0, xdo});
    end
  endtask : t_narrow

  task automatic t_write;
    logic [31:0] v[2] = '{32'h8001_7f00, 32'hfe03_55c1};
    mode = DBS_MODE_MEM;
    wr = 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      cpu = v[i];
      w(3);
      cmp("md write", v[i], mdo);
      cmp("md parity", {28'h0, par4(v[i])}, {28'h0, mpo});
      cmp("md oe", 32'h0, {31'h0, m_oe});
    end
  endtask : t_write

  task automatic t_asm;
    logic       h[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [1:0] s[4] = '{2'h0, 2'h1, 2'h0, 2'h1};
    logic [31:0] e[4] = '{32'h0011_0011, 32'h2211_2211,
                          32'h2233_2211, 32'h4433_2211};
    mode = DBS_MODE_PER;
    rd_n = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      half = h[i];
      xd = 8'(8'h11 * (i + 1));
      u_dbs_partner.pulse(s[i]);
      cmp("assembly", e[i], cdo);
    end
    cmp("halfword pin", 32'h1, {31'h0, hw_n});
  endtask : t_asm

  task automatic t_mread;
    logic [31:0] d[4] = '{32'h1234_5678, 32'h9abc_def0, 32'h0f0f_a5a5, 32'h3c3c_0001};
    logic [3:0]  bad[4] = '{4'h1, 4'h0, 4'h2, 4'h0};
    logic [3:0]  en[4] = '{4'h0, 4'h0, 4'h2, 4'h0};
    logic        f[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    mode = DBS_MODE_MEM;
    wr = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      md = d[i];
      mpar = par4(d[i]) ^ bad[i];
      lbe_n = en[i];
      u_dbs_partner.pulse(2'h2);
      md = ~d[i];
      w(3);
      cmp("md latch", d[i], cdo);
      cmp("fault", {31'h0, f[i]}, {31'h0, fault_n});
    end
  endtask : t_mread

  task automatic t_swap;
    mode = DBS_MODE_SLOT;
    sd = 16'hab00;
    u_dbs_partner.swap(1'b0, 1'b0);
    w(3);
    cmp("swap hi to lo", 32'hab, {24'h0, sdo[7:0]});
    sd = 16'h00cd;
    u_dbs_partner.swap(1'b1, 1'b0);
    w(3);
    cmp("swap lo to hi", 32'hcd, {24'h0, sdo[15:8]});
    u_dbs_partner.swap(1'b0, 1'b1);
  endtask : t_swap

  task automatic t_post;
    cache = 1'b1;
    mode  = DBS_MODE_MEM;
    wr    = 1'b1;
    cpu   = 32'h5aa5_c33c;
    pws   = 1'b1;
    w(4);
    pws   = 1'b0;
    cpu   = 32'h0bad_f00d;
    w(5);
    cmp("posted write", 32'h5aa5_c33c, mdo);
    cache = 1'b0;
    dcpu  = 1'b1;
    wr    = 1'b0;
    w(3);
    cmp("dram on cpu bus", 32'h4433_2211, cdo);
    dcpu  = 1'b0;
  endtask : t_post

  task automatic t_dma;
    mode = DBS_MODE_IDLE;
    hold = 1'b1;
    wr   = 1'b1;
    rd_n = 1'b0;
    xd   = 8'h5a;
    sd   = 16'hc300;
    w(3);
    cmp("dma xd to md", 32'h0000_c35a, mdo);
    cmp("dma md oe", 32'h0, {31'h0, m_oe});
    hold = 1'b0;
    mode = DBS_MODE_DMA;
    wr   = 1'b0;
    rd_n = 1'b1;
    md   = 32'h0000_7e81;
    w(3);
    cmp("dma md to xd", 32'h81, {24'h0, xdo});
    cmp("dma md to sd", 32'h7e81, {16'h0, sdo});
    cmp("dma sd xd oe", 32'h0, {30'h0, s_oe, x_oe});
  endtask : t_dma

  initial
  begin
    w(5);
    t_reset();
    rst_n = 1'b1;
    w(2);
    t_tri();
    t_s2s();
    t_narrow();
    t_write();
    t_asm();
    t_mread();
    t_swap();
    t_post();
    t_dma();
    summarize();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    #20000;
    n_errors++;
    summarize();
  end
endmodule : dbs_top_tb
